// ---- rtl/sfm_core.sv ----
// sfm_core: peripheral register space and operand address formation
//
// Behaviour
// R01: peripheral registers live at direct addresses 80h..ffh and only direct mode reaches them.
// R02: registers at addresses ending in 0 or 8 also take single-bit set, clear and test.
// R03: software must not write undefined bits, since that may upset the device.
// R04: immediate mode takes the constant from the instruction bytes and loads the destination.
// R05: direct mode takes the operand location from an 8-bit address field in the instruction.
// R06: direct addresses below 80h select the lower 128 bytes of data memory.
// R07: indirect mode uses pointer zero or one of the active bank as a lower memory address.
// R08: indexed mode reads program memory only and never writes or touches data memory.
// R09: indexed reads add the main working register to a 16-bit data pointer or program counter base.
// R10: the indexed jump loads the program counter with data pointer plus main working register.
// R11: register mode decodes a 3-bit opcode field to one of eight working registers.
// R12: the active bank comes from the two bank select bits of the program status word.
// R13: four banks of eight registers fill the lowest 32 bytes of data memory.
// R14: lower data memory spans 00h..7fh with the register space directly above it.
// R15: unmapped register addresses read a fixed harmless value and ignore writes.
`timescale 1ns/1ns
module sfm_core
  import sfm_pkg::*;
#(
  parameter int unsigned RAM_DEPTH = 128
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire sfm_pkg::sfm_req_t req,
  input  wire logic [15:0]       pc_now,
  output sfm_pkg::sfm_rsp_t      rsp,
  output logic [7:0]             main_reg_q,
  output logic [15:0]            data_ptr_q,
  output logic [1:0]             bank_q
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    SFM_ST_IDLE = 2'b00,
    SFM_ST_PTR  = 2'b01,
    SFM_ST_RAM  = 2'b10
  } sfm_state_t;

  typedef struct packed {
    sfm_state_t              st;
    sfm_req_t                hold;
    logic [7:0]              ram_addr;
    logic [REG_COUNT*8-1:0]  regs;
    sfm_rsp_t                rsp;
  } sfm_core_t;

  // implemented register addresses, one entry per register slot
  localparam logic [7:0] ADDR_TAB [REG_COUNT] = '{
    A_PORT0,
    A_SP,
    A_DPL,
    A_DPH,
    A_PWRC,
    A_TCTL,
    A_TMODE,
    A_T0L,
    A_T1L,
    A_T0H,
    A_T1H,
    A_PORT1,
    A_XFLAG,
    A_SCTL,
    A_SBUFR,
    A_PORT2,
    A_IEN,
    A_IPRI,
    A_ROSC,
    A_PMGT,
    A_XSTAT,
    A_PSWORD,
    A_P0KIND,
    A_P1KIND,
    A_P2KIND,
    A_WDCTL,
    A_PWCTL,
    A_PWDUTY,
    A_MAINREG,
    A_CENH,
    A_CENL,
    A_ALTF,
    A_P0PU,
    A_P1PU,
    A_P2PU,
    A_XIEN,
    A_CRESH,
    A_CCTL,
    A_MULOP,
    A_P0DIR,
    A_P1DIR,
    A_P2DIR,
    A_XIPRI
  };
  // reset values in the same slot order, undefined bits held at zero
  localparam logic [7:0] RST_TAB [REG_COUNT] = '{
    RST_FF,
    RST_SP,
    RST_00,
    RST_00,
    RST_PWR,
    RST_00,
    RST_00,
    RST_00,
    RST_00,
    RST_00,
    RST_00,
    RST_P1,
    RST_XF,
    RST_00,
    RST_00,
    RST_P2,
    RST_00,
    RST_IP,
    RST_OSC,
    RST_00,
    RST_00,
    RST_00,
    RST_FF,
    RST_P1,
    RST_P2,
    RST_WD,
    RST_00,
    RST_00,
    RST_00,
    RST_FF,
    RST_FF,
    RST_00,
    RST_00,
    RST_P1U,
    RST_00,
    RST_00,
    RST_00,
    RST_CC,
    RST_00,
    RST_FF,
    RST_P1,
    RST_P2,
    RST_00
  };
  localparam int unsigned IX_DPL  = 2;
  localparam int unsigned IX_DPH  = 3;
  localparam int unsigned IX_PSW  = 21;
  localparam int unsigned IX_MAIN = 28;

  initial begin
    if (RAM_DEPTH != RAM_WORDS) $error("sfm_core: RAM_DEPTH must be 128");
  end

  function automatic logic [REG_COUNT*8-1:0] reset_image();
    logic [REG_COUNT*8-1:0] v;
    v = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      v[i*8 +: 8] = RST_TAB[i];
    end
    return v;
  endfunction : reset_image

  // image folded into a constant so the reset branch loads constants only
  localparam logic [REG_COUNT*8-1:0] RST_IMAGE = reset_image();

  sfm_core_t  cur_ff;
  sfm_core_t  nxt_cur;
  logic       ram_we;
  logic [7:0] ram_wdata;
  logic [6:0] ram_raddr;
  logic [7:0] ram_rdata;

  // ****************************************************************
  // register hit decode, one comparator per register
  // ****************************************************************
  logic [REG_COUNT-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_hit
      assign hit[g] = (req.field == ADDR_TAB[g]);
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [7:0]  rd_sel;
  logic        mapped;
  logic [7:0]  wr_val;
  logic [1:0]  bank;
  logic [15:0] base;
  logic        is_reg_space;
  logic        bit_ok;

  always_comb begin
    nxt_cur   = cur_ff;
    ram_we    = 1'b0;
    ram_wdata = 8'h00;
    ram_raddr = 7'h00;
    rd_sel    = UNMAPPED_READ;
    mapped    = 1'b0;
    wr_val    = 8'h00;
    bank      = cur_ff.regs[IX_PSW*8+PSW_BANK_LO +: 2];  // [R12]
    base      = req.pc_base ? pc_now                    // [R09]
                : {cur_ff.regs[IX_DPH*8 +: 8], cur_ff.regs[IX_DPL*8 +: 8]};
    is_reg_space = req.field >= REG_SPACE_LO;           // [R14]
    bit_ok    = (req.field[2:0] == 3'h0);               // [R02]
    nxt_cur.rsp = '0;

    for (int i = 0; i < REG_COUNT; i++) begin
      if (hit[i]) begin
        rd_sel = cur_ff.regs[i*8 +: 8];
        mapped = 1'b1;
      end
    end

    case (cur_ff.st)
      SFM_ST_IDLE: begin
        if (req.valid) begin
          nxt_cur.hold = req;
          case (req.mode)
            SFM_MODE_IMM: begin
              // constant comes straight from instruction bytes [R04]
              nxt_cur.rsp.valid = 1'b1;
              nxt_cur.rsp.rdata = req.wdata;
            end
            SFM_MODE_DIR: begin
              if (is_reg_space) begin  // [R01] [R05]
                nxt_cur.rsp.valid = 1'b1;
                if (req.bit_acc && !bit_ok) begin
                  nxt_cur.rsp.refused = 1'b1;  // [R02]
                end else if (!mapped) begin
                  nxt_cur.rsp.rdata = UNMAPPED_READ;  // [R15]
                end else begin
                  case (req.op)
                    SFM_OP_WRITE: wr_val = req.wdata;
                    SFM_OP_BSET:  wr_val = rd_sel | (8'h01 << req.bit_sel);  // [R02]
                    SFM_OP_BCLR:  wr_val = rd_sel & ~(8'h01 << req.bit_sel); // [R02]
                    default:      wr_val = rd_sel;
                  endcase
                  nxt_cur.rsp.rdata   = rd_sel;
                  nxt_cur.rsp.bit_val = rd_sel[req.bit_sel];  // [R02]
                  // undefined bits are stored as written; software keeps off them [R03]
                  for (int i = 0; i < REG_COUNT; i++) begin
                    if (hit[i] && req.op != SFM_OP_READ) begin
                      nxt_cur.regs[i*8 +: 8] = wr_val;
                    end
                  end
                end
              end else begin
                nxt_cur.ram_addr = req.field;  // [R06]
                ram_raddr        = req.field[6:0];
                nxt_cur.st       = SFM_ST_RAM;
              end
            end
            SFM_MODE_IND: begin
              // pointer zero or one of the active bank, read first [R07] [R13]
              nxt_cur.ram_addr = {3'h0, bank, 2'h0, req.field[0]};
              ram_raddr        = {2'h0, bank, 2'h0, req.field[0]};
              nxt_cur.st       = SFM_ST_PTR;
            end
            SFM_MODE_REG: begin
              // 3-bit field selects a working register in the bank [R11] [R12] [R13]
              nxt_cur.ram_addr = {3'h0, bank, req.field[2:0]};
              ram_raddr        = {2'h0, bank, req.field[2:0]};
              nxt_cur.st       = SFM_ST_RAM;
            end
            SFM_MODE_IDX: begin
              // program memory read only, no write path at all [R08] [R09]
              nxt_cur.rsp.valid   = 1'b1;
              nxt_cur.rsp.pm_rd   = 1'b1;
              nxt_cur.rsp.pm_addr = base + {8'h00, cur_ff.regs[IX_MAIN*8 +: 8]};
              nxt_cur.rsp.refused = (req.op != SFM_OP_READ);  // [R08]
            end
            SFM_MODE_JMP: begin
              nxt_cur.rsp.valid   = 1'b1;  // [R10]
              nxt_cur.rsp.pc_load = 1'b1;
              nxt_cur.rsp.pc_val  = {cur_ff.regs[IX_DPH*8 +: 8], cur_ff.regs[IX_DPL*8 +: 8]}
                                    + {8'h00, cur_ff.regs[IX_MAIN*8 +: 8]};
            end
            default: begin
              nxt_cur.rsp.valid   = 1'b1;
              nxt_cur.rsp.refused = 1'b1;
            end
          endcase
        end
      end
      SFM_ST_PTR: begin
        // pointer content must stay in lower memory [R07]
        nxt_cur.ram_addr = {1'b0, ram_rdata[6:0]};
        ram_raddr        = ram_rdata[6:0];
        if (ram_rdata > RAM_LAST) begin
          nxt_cur.rsp.valid   = 1'b1;
          nxt_cur.rsp.refused = 1'b1;
          nxt_cur.st          = SFM_ST_IDLE;
        end else begin
          nxt_cur.st = SFM_ST_RAM;
        end
      end
      SFM_ST_RAM: begin
        nxt_cur.rsp.valid   = 1'b1;
        nxt_cur.rsp.rdata   = ram_rdata;
        nxt_cur.rsp.bit_val = ram_rdata[cur_ff.hold.bit_sel];
        if (cur_ff.hold.op == SFM_OP_WRITE) begin  // [R06] [R07]
          ram_we    = 1'b1;
          ram_wdata = cur_ff.hold.wdata;
        end
        nxt_cur.st = SFM_ST_IDLE;
      end
      default: begin
        nxt_cur.st = SFM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cur_ff.st       <= SFM_ST_IDLE;
      cur_ff.hold     <= '0;
      cur_ff.ram_addr <= 8'h00;
      cur_ff.regs     <= RST_IMAGE;
      cur_ff.rsp      <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************************************
  // lower data memory
  // ****************************************************************
  sfm_ram #(
    .WORDS (RAM_WORDS),
    .AWID  (7)
  ) u_ram (
    .mclk  (mclk),
    .we    (ram_we),
    .waddr (cur_ff.ram_addr[6:0]),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  assign rsp        = cur_ff.rsp;
  assign main_reg_q = cur_ff.regs[IX_MAIN*8 +: 8];
  assign data_ptr_q = {cur_ff.regs[IX_DPH*8 +: 8], cur_ff.regs[IX_DPL*8 +: 8]};
  assign bank_q     = cur_ff.regs[IX_PSW*8+PSW_BANK_LO +: 2];

endmodule : sfm_core

// ---- common/sfm_pkg.sv ----
// sfm_pkg: constants and carriers for the register map and operand address former
package sfm_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;
  localparam int unsigned PW = 16;

  // lower data memory and banks
  localparam logic [7:0] RAM_LAST      = 8'h7f;
  localparam logic [7:0] REG_SPACE_LO  = 8'h80;
  localparam int unsigned RAM_WORDS    = 128;
  localparam int unsigned BANK_REGS    = 8;
  localparam int unsigned BANK_COUNT   = 4;
  localparam int unsigned PSW_BANK_LO  = 3;
  localparam int unsigned PSW_BANK_HI  = 4;

  // register offsets
  localparam logic [7:0] A_PORT0   = 8'h80;
  localparam logic [7:0] A_SP      = 8'h81;
  localparam logic [7:0] A_DPL     = 8'h82;
  localparam logic [7:0] A_DPH     = 8'h83;
  localparam logic [7:0] A_PWRC    = 8'h87;
  localparam logic [7:0] A_TCTL    = 8'h88;
  localparam logic [7:0] A_TMODE   = 8'h89;
  localparam logic [7:0] A_T0L     = 8'h8a;
  localparam logic [7:0] A_T1L     = 8'h8b;
  localparam logic [7:0] A_T0H     = 8'h8c;
  localparam logic [7:0] A_T1H     = 8'h8d;
  localparam logic [7:0] A_PORT1   = 8'h90;
  localparam logic [7:0] A_XFLAG   = 8'h91;
  localparam logic [7:0] A_SCTL    = 8'h98;
  localparam logic [7:0] A_SBUFR   = 8'h99;
  localparam logic [7:0] A_PORT2   = 8'ha0;
  localparam logic [7:0] A_IEN     = 8'ha8;
  localparam logic [7:0] A_IPRI    = 8'hb8;
  localparam logic [7:0] A_ROSC    = 8'hbe;
  localparam logic [7:0] A_PMGT    = 8'hc4;
  localparam logic [7:0] A_XSTAT   = 8'hc5;
  localparam logic [7:0] A_PSWORD  = 8'hd0;
  localparam logic [7:0] A_P0KIND  = 8'hd4;
  localparam logic [7:0] A_P1KIND  = 8'hd5;
  localparam logic [7:0] A_P2KIND  = 8'hd6;
  localparam logic [7:0] A_WDCTL   = 8'hd8;
  localparam logic [7:0] A_PWCTL   = 8'hdc;
  localparam logic [7:0] A_PWDUTY  = 8'hde;
  localparam logic [7:0] A_MAINREG = 8'he0;
  localparam logic [7:0] A_CENH    = 8'he1;
  localparam logic [7:0] A_CENL    = 8'he2;
  localparam logic [7:0] A_ALTF    = 8'he3;
  localparam logic [7:0] A_P0PU    = 8'he4;
  localparam logic [7:0] A_P1PU    = 8'he5;
  localparam logic [7:0] A_P2PU    = 8'he6;
  localparam logic [7:0] A_XIEN    = 8'he8;
  localparam logic [7:0] A_CRESH   = 8'hee;
  localparam logic [7:0] A_CCTL    = 8'hef;
  localparam logic [7:0] A_MULOP   = 8'hf0;
  localparam logic [7:0] A_P0DIR   = 8'hf4;
  localparam logic [7:0] A_P1DIR   = 8'hf5;
  localparam logic [7:0] A_P2DIR   = 8'hf6;
  localparam logic [7:0] A_XIPRI   = 8'hf8;
  localparam int unsigned REG_COUNT = 43;

  // undefined bits reset to zero
  localparam logic [7:0] RST_FF  = 8'hff;
  localparam logic [7:0] RST_00  = 8'h00;
  localparam logic [7:0] RST_SP  = 8'h07;
  localparam logic [7:0] RST_PWR = 8'h10;
  localparam logic [7:0] RST_P1  = 8'h07;
  localparam logic [7:0] RST_XF  = 8'h05;
  localparam logic [7:0] RST_P2  = 8'h7f;
  localparam logic [7:0] RST_IP  = 8'h80;
  localparam logic [7:0] RST_OSC = 8'h04;
  localparam logic [7:0] RST_WD  = 8'hd0;
  localparam logic [7:0] RST_CC  = 8'h20;
  localparam logic [7:0] RST_P1U = 8'h03;
  // value returned for an unmapped register address
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  typedef enum logic [2:0] {
    SFM_MODE_IMM  = 3'b000,
    SFM_MODE_DIR  = 3'b001,
    SFM_MODE_IND  = 3'b010,
    SFM_MODE_IDX  = 3'b011,
    SFM_MODE_REG  = 3'b100,
    SFM_MODE_JMP  = 3'b101
  } sfm_mode_t;

  typedef enum logic [1:0] {
    SFM_OP_READ  = 2'b00,
    SFM_OP_WRITE = 2'b01,
    SFM_OP_BSET  = 2'b10,
    SFM_OP_BCLR  = 2'b11
  } sfm_op_t;

  // one operand request from the execution logic
  typedef struct packed {
    logic       valid;
    sfm_mode_t  mode;
    sfm_op_t    op;
    logic       bit_acc;
    logic [2:0] bit_sel;
    logic [7:0] field;
    logic [7:0] wdata;
    logic       pc_base;
  } sfm_req_t;

  // one answer to the execution logic
  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        bit_val;
    logic        pm_rd;
    logic [15:0] pm_addr;
    logic        pc_load;
    logic [15:0] pc_val;
    logic        refused;
  } sfm_rsp_t;

endpackage : sfm_pkg

// ---- rtl/sfm_ram.sv ----
// sfm_ram: lower internal data memory with registered read data
`timescale 1ns/1ns
module sfm_ram #(
  parameter int unsigned WORDS = 128,
  parameter int unsigned AWID  = 7
) (
  input  wire logic            mclk,
  input  wire logic            we,
  input  wire logic [AWID-1:0] waddr,
  input  wire logic [7:0]      wdata,
  input  wire logic [AWID-1:0] raddr,
  output logic      [7:0]      rdata
);

  logic [7:0] mem [WORDS];

  initial begin
    if (WORDS != (1 << AWID)) $error("sfm_ram: WORDS must equal 2**AWID");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : sfm_ram

// ---- dv/sfm_core_props.sv ----
// sfm_core_props: concurrent checks on the operand port of the register map
`timescale 1ns/1ns
module sfm_core_props (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire sfm_pkg::sfm_req_t req,
  input  wire logic [15:0]       pc_now,
  input  wire sfm_pkg::sfm_rsp_t rsp,
  input  wire logic [7:0]        main_reg_q,
  input  wire logic [15:0]       data_ptr_q,
  input  wire logic [1:0]        bank_q
);
  import sfm_pkg::*;
  // ******************************
  // request tracking and checks
  // ******************************
  logic busy_ff;
  logic nxt_busy;
  logic take;
  // a request only counts when no answer is outstanding
  assign take = req.valid && !busy_ff;
  always_comb nxt_busy = take ? 1'b1 : (rsp.valid ? 1'b0 : busy_ff);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_imm_const_echo: assert property (take && req.mode == SFM_MODE_IMM |=> rsp.valid
    && rsp.rdata == $past(req.wdata)) else $error("immediate answer wrong");
  a_dir_reg_fast: assert property (take && req.mode == SFM_MODE_DIR && req.field[7]
    |=> rsp.valid) else $error("register access not answered in one cycle");
  a_dir_ram_two: assert property (take && req.mode == SFM_MODE_DIR && !req.field[7]
    |=> !rsp.valid ##1 rsp.valid) else $error("low memory direct access latency wrong");
  a_bit_aligned_only: assert property (take && req.mode == SFM_MODE_DIR && req.bit_acc
    && req.field[7] |=> rsp.valid && rsp.refused == ($past(req.field[2:0]) != 3'h0))
    else $error("bit access refusal wrong");
  a_ind_ptr_lat: assert property (take && req.mode == SFM_MODE_IND |=> !rsp.valid
    ##1 ((rsp.valid && rsp.refused) or (!rsp.valid ##1 (rsp.valid && !rsp.refused))))
    else $error("indirect access latency wrong");
  a_idx_base_sum: assert property (take && req.mode == SFM_MODE_IDX |=> rsp.pm_rd
    && rsp.pm_addr == ($past(req.pc_base) ? $past(pc_now) : $past(data_ptr_q))
    + {8'h00, $past(main_reg_q)}) else $error("table read address wrong");
  a_idx_read_only: assert property (take && req.mode == SFM_MODE_IDX |=>
    rsp.refused == ($past(req.op) != SFM_OP_READ) && $stable(main_reg_q)
    && $stable(data_ptr_q) && $stable(bank_q)) else $error("table read wrote state");
  a_jump_data_pointer_sum: assert property (take && req.mode == SFM_MODE_JMP |=> rsp.pc_load
    && rsp.pc_val == $past(data_ptr_q) + {8'h00, $past(main_reg_q)})
    else $error("jump target wrong");
  a_reg_mode_two: assert property (take && req.mode == SFM_MODE_REG |=> !rsp.valid
    ##1 rsp.valid) else $error("register mode latency wrong");
  a_bank_from_psw: assert property (take && req.mode == SFM_MODE_DIR && !req.bit_acc
    && req.op == SFM_OP_WRITE && req.field == A_PSWORD |=> bank_q == $past(req.wdata[4:3])
    or ##1 bank_q == $past(req.wdata[4:3], 2)) else $error("bank select not followed");
endmodule : sfm_core_props

// ---- dv/sfm_exec_model.sv ----
// sfm_exec_model: execution-side requester that issues operand requests and collects answers
`timescale 1ns/1ns
module sfm_exec_model (
  input  wire logic              mclk,
  input  wire sfm_pkg::sfm_rsp_t rsp,
  output sfm_pkg::sfm_req_t      req
);
  import sfm_pkg::*;
  // ******************************
  // request driver
  // ******************************
  initial begin
    req = '0;
  end
  task automatic issue(input sfm_req_t c, output sfm_rsp_t r, output logic ok);
    int n;
    n = 0;
    @(negedge mclk);
    req = c;
    @(negedge mclk);
    // released lines change so a stale value can never pass for a live one
    req.valid = 1'b0;
    req.field = ~c.field;
    req.wdata = ~c.wdata;
    while (n < 8 && rsp.valid !== 1'b1) begin
      @(negedge mclk);
      n++;
    end
    r = rsp;
    ok = (rsp.valid === 1'b1);
  endtask : issue
endmodule : sfm_exec_model

// ---- dv/sfm_core_tb.sv ----
// sfm_core_tb: random and corner-case bench for the register map and operand address former
`timescale 1ns/1ns
`define CHK(act, exp) begin \
  cmp_count++; \
  if ((act) !== (exp)) begin \
    mismatches++; \
    $display("ERROR at %0t: got %h expected %h", $time, (act), (exp)); \
  end \
end
module sfm_core_tb;
  import sfm_pkg::*;
  // ******************************
  // bench
  // ******************************
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] pc_now = 16'h0000;
  sfm_req_t    req;
  sfm_rsp_t    rsp;
  sfm_rsp_t    got;
  logic [7:0]  main_reg_q;
  logic [15:0] data_ptr_q;
  logic [1:0]  bank_q;
  logic [7:0]  shadow [256];
  logic [7:0]  a;
  logic [7:0]  d;
  logic [7:0]  p;
  logic [2:0]  b;
  int          k;
  int          seed = 88;
  int          cycles = 0;
  int          mismatches = 0;
  int          cmp_count = 0;
  // address, reset value (undefined bits 0), mask of defined bits
  logic [23:0] rtab [43] = '{24'h80ffff, 24'h8107ff, 24'h8200ff, 24'h8300ff, 24'h87109f,
    24'h8800ff, 24'h89000f, 24'h8a00ff, 24'h8b00ff, 24'h8c00ff, 24'h8d00ff, 24'h900707,
    24'h91053f, 24'h980013, 24'h9900ff, 24'ha07f7f, 24'ha800df, 24'hb880df, 24'hbe0407,
    24'hc40008, 24'hc50010, 24'hd000ff, 24'hd4ffff, 24'hd50707, 24'hd67f7f, 24'hd8d0ff,
    24'hdc00f7, 24'hde00ff, 24'he000ff, 24'he1ffff, 24'he2ffff, 24'he300fc, 24'he400ff,
    24'he50303, 24'he6007f, 24'he80033, 24'hee00ff, 24'hef20ff, 24'hf000ff, 24'hf4ffff,
    24'hf50707, 24'hf67f7f, 24'hf80033};
  sfm_core #(.RAM_DEPTH(128)) u_sfm_core (.mclk(mclk), .rstn(rstn), .req(req),
    .pc_now(pc_now), .rsp(rsp), .main_reg_q(main_reg_q), .data_ptr_q(data_ptr_q),
    .bank_q(bank_q));
  sfm_exec_model u_sfm_exec_model (.mclk(mclk), .rsp(rsp), .req(req));
  always #5 mclk = ~mclk;
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // the whole run needs under two thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic op(input sfm_mode_t m, input sfm_op_t o, input logic ba, input logic [2:0] bs,
                    input logic [7:0] f, input logic [7:0] w, input logic pb);
    logic ok;
    u_sfm_exec_model.issue('{1'b1, m, o, ba, bs, f, w, pb}, got, ok);
    `CHK(ok, 1'b1)
  endtask : op
  task automatic sweep(input string name);
    for (int i = 0; i < 43; i++) begin
      op(SFM_MODE_DIR, SFM_OP_READ, 1'b0, 3'h0, rtab[i][23:16], 8'h00, 1'b0);
      `CHK(got.rdata, shadow[rtab[i][23:16]])
    end
    $display("test %s done", name);
  endtask : sweep
  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 43; i++) shadow[rtab[i][23:16]] = rtab[i][15:8];
    sweep("reset_values");
  endtask : do_reset
  initial begin
    do_reset();
    op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, 8'h84, 8'h5a, 1'b0);
    op(SFM_MODE_DIR, SFM_OP_READ, 1'b0, 3'h0, 8'h84, 8'h00, 1'b0);
    `CHK(got.rdata, UNMAPPED_READ)
    for (int i = 0; i < 120; i++) begin
      k = $unsigned($random(seed)) % 43;
      a = rtab[k][23:16];
      d = 8'($random(seed));
      b = 3'($random(seed));
      // undefined bits keep what they hold
      d = (shadow[a] & ~rtab[k][7:0]) | (d & rtab[k][7:0]);
      op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, a, d, 1'b0);
      `CHK(got.rdata, shadow[a])
      shadow[a] = d;
      if (a[2:0] == 3'h0 && rtab[k][b]) begin
        op(SFM_MODE_DIR, d[0] ? SFM_OP_BCLR : SFM_OP_BSET, 1'b1, b, a, 8'h00, 1'b0);
        shadow[a][b] = ~d[0];
        op(SFM_MODE_DIR, SFM_OP_READ, 1'b1, b, a, 8'h00, 1'b0);
        `CHK(got.bit_val, ~d[0])
      end
    end
    op(SFM_MODE_DIR, SFM_OP_BSET, 1'b1, 3'h2, A_SP, 8'h00, 1'b0);
    `CHK(got.refused, 1'b1)
    sweep("register_random");
    for (int i = 0; i < 128; i++) begin
      d = 8'($random(seed));
      op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, 8'(i), d, 1'b0);
      shadow[i] = d;
    end
    for (int i = 0; i < 40; i++) begin
      a = (i == 0) ? 8'h7f : 8'($unsigned($random(seed)) % 128);
      op(SFM_MODE_DIR, SFM_OP_READ, 1'b0, 3'h0, a, 8'h00, 1'b0);
      `CHK(got.rdata, shadow[a])
    end
    $display("test low_memory done");
    for (int bk = 0; bk < 4; bk++) begin
      d = shadow[A_PSWORD];
      d[4:3] = bk[1:0];
      op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, A_PSWORD, d, 1'b0);
      shadow[A_PSWORD] = d;
      for (int s = 0; s < 2; s++) begin
        p = 8'($random(seed));
        p[7] = (bk == 3) && (s == 1);
        op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, 8'(bk * 8 + s), p, 1'b0);
        shadow[bk * 8 + s] = p;
        op(SFM_MODE_IND, SFM_OP_READ, 1'b0, 3'h0, 8'(s), 8'h00, 1'b0);
        if (p[7]) `CHK(got.refused, 1'b1)
        else `CHK(got.rdata, shadow[p])
        if (!p[7] && s == 0) begin
          op(SFM_MODE_IND, SFM_OP_WRITE, 1'b0, 3'h0, 8'(s), ~p, 1'b0);
          shadow[p] = ~p;
          op(SFM_MODE_DIR, SFM_OP_READ, 1'b0, 3'h0, p, 8'h00, 1'b0);
          `CHK(got.rdata, ~p)
        end
      end
      for (int r = 0; r < 8; r++) begin
        if (r == 7) begin
          d = 8'($random(seed));
          op(SFM_MODE_REG, SFM_OP_WRITE, 1'b0, 3'h0, 8'(r), d, 1'b0);
          `CHK(got.rdata, shadow[bk * 8 + r])
          shadow[bk * 8 + r] = d;
        end
        op(SFM_MODE_REG, SFM_OP_READ, 1'b0, 3'h0, 8'(r), 8'h00, 1'b0);
        `CHK(got.rdata, shadow[bk * 8 + r])
      end
      `CHK(bank_q, bk[1:0])
    end
    $display("test banks done");
    for (int i = 0; i < 20; i++) begin
      pc_now = 16'($random(seed));
      d = 8'($random(seed));
      op(SFM_MODE_DIR, SFM_OP_WRITE, 1'b0, 3'h0, A_MAINREG, d, 1'b0);
      shadow[A_MAINREG] = d;
      `CHK(main_reg_q, d)
      `CHK(data_ptr_q, {shadow[A_DPH], shadow[A_DPL]})
      op(SFM_MODE_IDX, i[0] ? SFM_OP_WRITE : SFM_OP_READ, 1'b0, 3'h0, 8'h00, d, i[1]);
      `CHK(got.pm_addr, (i[1] ? pc_now : {shadow[A_DPH], shadow[A_DPL]}) + {8'h00, d})
      `CHK({got.pm_rd, got.refused}, {1'b1, i[0]})
      op(SFM_MODE_JMP, SFM_OP_READ, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
      `CHK({got.pc_load, got.pc_val}, {1'b1, {shadow[A_DPH], shadow[A_DPL]} + {8'h00, d}})
      op(SFM_MODE_IMM, SFM_OP_READ, 1'b0, 3'h0, 8'h00, ~d, 1'b0);
      `CHK(got.rdata, ~d)
    end
    sweep("indexed_and_immediate");
    do_reset();
    test_done();
  end
endmodule : sfm_core_tb
bind sfm_core sfm_core_props u_sfm_core_props (.mclk(mclk), .rstn(rstn), .req(req),
  .pc_now(pc_now), .rsp(rsp), .main_reg_q(main_reg_q), .data_ptr_q(data_ptr_q),
  .bank_q(bank_q));
